// ===== core/dod_ctrl_regs.sv
/*
 * apb slave for the converter output stage control registers, with
 * decode of each field onto the analogue control outputs.
 * assumes apb3 master, 50 mhz pclk, byte addresses four times the index.
 */
`timescale 1ns/1ps
module dod_ctrl_regs (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [dod_pkg::DOD_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// analogue stage controls
	output dod_pkg::dod_ctrl_s ctrl
);
	import dod_pkg::*;

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		dod_state_e phase;
		logic [31:0] rdata;
		logic err;
	} dod_bus_s;

	dod_bus_s st_reg;
	dod_bus_s st_next;
	dod_apb_req_s req;
	logic [31:0] regs;
	logic [7:0] pwr_b;
	logic [7:0] hpd_b;
	logic [7:0] osc_b;
	logic [7:0] rte_b;
	logic hit;
	logic [1:0] sel;
	logic rsv_hit;
	logic wr_en;

	assign req = '{psel, penable, pwrite, paddr, pwdata};
	assign {rte_b, osc_b, hpd_b, pwr_b} = regs;

	// ************************************************************
	// address decode
	// ************************************************************
	// reserved slot is mapped so it answers without error
	always_comb begin
		hit = 1'b1;
		sel = 2'h0;
		rsv_hit = 1'b0;
		if (req.paddr == dod_addr(DOD_IDX_PWR)) begin
			sel = 2'h0;
		end else if (req.paddr == dod_addr(DOD_IDX_HPD)) begin
			sel = 2'h1;
		end else if (req.paddr == dod_addr(DOD_IDX_OSC)) begin
			sel = 2'h2;
		end else if (req.paddr == dod_addr(DOD_IDX_RTE)) begin
			sel = 2'h3;
		end else if (req.paddr == dod_addr(DOD_IDX_RSV)) begin
			rsv_hit = 1'b1;
		end else begin
			hit = 1'b0;
		end
	end

	function automatic logic [7:0] dod_read(input logic [1:0] s, input logic [31:0] r);
		return r[s*8 +: 8];
	endfunction

	// ************************************************************
	// bus phase machine
	// ************************************************************
	// answers in the first access cycle; read data registered at setup
	always_comb begin
		st_next = st_reg;
		unique case (st_reg.phase)
			DOD_ST_IDLE: begin
				if (req.psel && !req.penable) begin
					st_next.phase = DOD_ST_ACC;
					st_next.err = !hit;
					st_next.rdata = 32'h0;
					if (hit && !rsv_hit && !req.pwrite) begin
						st_next.rdata = {24'h0, dod_read(sel, regs)};
					end
				end
			end
			DOD_ST_ACC: begin
				st_next.phase = DOD_ST_IDLE;
			end
			default: begin
				st_next.phase = DOD_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '{DOD_ST_IDLE, 32'h0, 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign pready = (st_reg.phase == DOD_ST_ACC);
	assign pslverr = pready && st_reg.err;
	assign prdata = st_reg.rdata;

	// writes land at the completing edge; reserved slot write is dropped
	assign wr_en = pready && req.psel && req.penable && req.pwrite && hit && !rsv_hit;

	dod_regfile u_rf (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(wr_en),
		.wr_sel(sel),
		.wr_data(req.pwdata[7:0]),
		.regs(regs)
	);

	// ************************************************************
	// field decode onto the analogue controls
	// ************************************************************
	// reserved codes are stored as written but fall back to safe
	// modes here, since the host is expected never to write them
	always_comb begin
		ctrl.left_dac_power = pwr_b[DOD_POS_LPWR];
		ctrl.right_dac_power = pwr_b[DOD_POS_RPWR];
		ctrl.left_companion_driver_mode = pwr_b[DOD_POS_LCOM +: 2];
		if (pwr_b[DOD_POS_LCOM +: 2] == DOD_CODE2_RSV) begin
			ctrl.left_companion_driver_mode = 2'h0;
		end
		ctrl.right_companion_driver_mode = hpd_b[DOD_POS_RCOM +: 3];
		if (hpd_b[DOD_POS_RCOM +: 3] > DOD_RCOM_MAX) begin
			ctrl.right_companion_driver_mode = 3'h0;
		end
		ctrl.short_protect_en = hpd_b[DOD_POS_SCEN];
		ctrl.short_protect_shutdown = hpd_b[DOD_POS_SCEN] && hpd_b[DOD_POS_SCMD];
		ctrl.current_limit_active = hpd_b[DOD_POS_SCEN] && !hpd_b[DOD_POS_SCMD];
		ctrl.common_mode_level = osc_b[DOD_POS_CML +: 2];
		ctrl.left_line_input_b_bypass = osc_b[DOD_POS_LBYP +: 2];
		ctrl.right_line_input_b_bypass = osc_b[DOD_POS_RBYP +: 2];
		ctrl.soft_step_mode = osc_b[DOD_POS_STEP +: 2];
		if (osc_b[DOD_POS_STEP +: 2] == DOD_CODE2_RSV) begin
			ctrl.soft_step_mode = 2'h2;
		end
		ctrl.left_path_sel = rte_b[DOD_POS_LRTE +: 2];
		if (rte_b[DOD_POS_LRTE +: 2] == DOD_CODE2_RSV) begin
			ctrl.left_path_sel = 2'h0;
		end
		ctrl.right_path_sel = rte_b[DOD_POS_RRTE +: 2];
		if (rte_b[DOD_POS_RRTE +: 2] == DOD_CODE2_RSV) begin
			ctrl.right_path_sel = 2'h0;
		end
		ctrl.left_vol_follows_right = rte_b[DOD_POS_LINK +: 2] == DOD_LINK_L_FOLLOWS_R;
		ctrl.right_vol_follows_left = rte_b[DOD_POS_LINK +: 2] == DOD_LINK_R_FOLLOWS_L;
	end

	// ************************************************************
	// checks
	// ************************************************************
	sequence s_pwr_write;
		wr_en && sel == 2'h0;
	endsequence

	sequence s_hpd_write;
		wr_en && sel == 2'h1;
	endsequence

	// one sequence per register write, each the first step of an apply check
	sequence s_osc_write;
		wr_en && sel == 2'h2;
	endsequence

	sequence s_rte_write;
		wr_en && sel == 2'h3;
	endsequence

	a_left_power: assert property (@(posedge pclk) disable iff (!presetn)
		s_pwr_write |=> ctrl.left_dac_power == $past(pwdata[DOD_POS_LPWR]))
		else $error("left power bit not applied");

	a_right_power: assert property (@(posedge pclk) disable iff (!presetn)
		s_pwr_write |=> ctrl.right_dac_power == $past(pwdata[DOD_POS_RPWR]))
		else $error("right power bit not applied");

	a_left_comp_legal: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl.left_companion_driver_mode != DOD_CODE2_RSV)
		else $error("left companion mode reserved");

	a_right_comp_legal: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl.right_companion_driver_mode <= DOD_RCOM_MAX)
		else $error("right companion mode reserved");

	a_protect_enable: assert property (@(posedge pclk) disable iff (!presetn)
		s_hpd_write |=> ctrl.short_protect_en == $past(pwdata[DOD_POS_SCEN]))
		else $error("protection enable not applied");

	a_protect_mode: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl.short_protect_shutdown |-> ctrl.short_protect_en && !ctrl.current_limit_active)
		else $error("protection mode inconsistent");

	a_rsv_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && !pwrite && paddr == dod_addr(DOD_IDX_RSV) |=> prdata == 32'h0)
		else $error("reserved slot read nonzero");

	a_cm_level: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && sel == 2'h2 |=> ctrl.common_mode_level == $past(pwdata[DOD_POS_CML +: 2]))
		else $error("common mode level not applied");

	a_soft_step: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl.soft_step_mode != DOD_CODE2_RSV)
		else $error("soft step mode reserved");

	a_vol_link: assert property (@(posedge pclk) disable iff (!presetn)
		!(ctrl.left_vol_follows_right && ctrl.right_vol_follows_left))
		else $error("both volume links active");

	a_answer_next: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable |=> pready ##1 !pready)
		else $error("apb answer not one cycle after setup");

	// ************************************************************
	// field application checks, then bus response, hold and reset checks
	// ************************************************************
	// only legal codes must pass through unchanged; reserved codes are
	// the host's fault; companion and soft-step ones fall under the legality checks above, routing ones under none
	a_left_comp_apply: assert property (@(posedge pclk) disable iff (!presetn)
		(s_pwr_write ##0 pwdata[DOD_POS_LCOM +: 2] != DOD_CODE2_RSV)
		|=> ctrl.left_companion_driver_mode == $past(pwdata[DOD_POS_LCOM +: 2]))
		else $error("left companion mode not applied");

	a_right_comp_apply: assert property (@(posedge pclk) disable iff (!presetn)
		(s_hpd_write ##0 pwdata[DOD_POS_RCOM +: 3] <= DOD_RCOM_MAX)
		|=> ctrl.right_companion_driver_mode == $past(pwdata[DOD_POS_RCOM +: 3]))
		else $error("right companion mode not applied");

	a_protect_shut: assert property (@(posedge pclk) disable iff (!presetn)
		s_hpd_write |=> ctrl.short_protect_shutdown
			== ($past(pwdata[DOD_POS_SCEN]) && $past(pwdata[DOD_POS_SCMD])))
		else $error("automatic shutdown not applied");

	a_protect_limit: assert property (@(posedge pclk) disable iff (!presetn)
		s_hpd_write |=> ctrl.current_limit_active
			== ($past(pwdata[DOD_POS_SCEN]) && !$past(pwdata[DOD_POS_SCMD])))
		else $error("current limit not applied");

	a_left_bypass: assert property (@(posedge pclk) disable iff (!presetn)
		s_osc_write
		|=> ctrl.left_line_input_b_bypass == $past(pwdata[DOD_POS_LBYP +: 2]))
		else $error("left bypass not applied");

	a_right_bypass: assert property (@(posedge pclk) disable iff (!presetn)
		s_osc_write
		|=> ctrl.right_line_input_b_bypass == $past(pwdata[DOD_POS_RBYP +: 2]))
		else $error("right bypass not applied");

	a_step_apply: assert property (@(posedge pclk) disable iff (!presetn)
		(s_osc_write ##0 pwdata[DOD_POS_STEP +: 2] != DOD_CODE2_RSV)
		|=> ctrl.soft_step_mode == $past(pwdata[DOD_POS_STEP +: 2]))
		else $error("soft step mode not applied");

	a_left_route: assert property (@(posedge pclk) disable iff (!presetn)
		(s_rte_write ##0 pwdata[DOD_POS_LRTE +: 2] != DOD_CODE2_RSV)
		|=> ctrl.left_path_sel == $past(pwdata[DOD_POS_LRTE +: 2]))
		else $error("left routing not applied");

	a_right_route: assert property (@(posedge pclk) disable iff (!presetn)
		(s_rte_write ##0 pwdata[DOD_POS_RRTE +: 2] != DOD_CODE2_RSV)
		|=> ctrl.right_path_sel == $past(pwdata[DOD_POS_RRTE +: 2]))
		else $error("right routing not applied");

	a_link_left: assert property (@(posedge pclk) disable iff (!presetn)
		s_rte_write |=> ctrl.left_vol_follows_right
			== ($past(pwdata[DOD_POS_LINK +: 2]) == DOD_LINK_L_FOLLOWS_R))
		else $error("left volume link not applied");

	a_link_right: assert property (@(posedge pclk) disable iff (!presetn)
		s_rte_write |=> ctrl.right_vol_follows_left
			== ($past(pwdata[DOD_POS_LINK +: 2]) == DOD_LINK_R_FOLLOWS_L))
		else $error("right volume link not applied");

	// reserved slot answers cleanly, only unmapped addresses error
	a_slot_errors: assert property (@(posedge pclk) disable iff (!presetn)
		pready |-> pslverr == !hit)
		else $error("error response does not match address map");

	a_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
		pready |-> prdata[31:8] == 24'h0)
		else $error("read data upper bytes not zero");

	a_unmapped_drop: assert property (@(posedge pclk) disable iff (!presetn)
		pready && psel && penable && pwrite && !hit |=> $stable(regs))
		else $error("unmapped write changed a register");

	a_hold_no_write: assert property (@(posedge pclk) disable iff (!presetn)
		!wr_en |=> $stable(regs))
		else $error("register changed without a write");

	a_ctrl_reset: assert property (@(posedge pclk) $rose(presetn) |-> ctrl == '0)
		else $error("controls not cleared by reset");
endmodule

// ===== core/dod_regfile.sv
/*
 * the four writable control bytes of the output stage group.
 * assumes the caller qualifies the write strobe with a completed apb access.
 */
`timescale 1ns/1ps
module dod_regfile (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// write side
	input wire logic wr_en,
	input wire logic [1:0] wr_sel,
	input wire logic [7:0] wr_data,
	// stored bytes
	output logic [31:0] regs
);
	import dod_pkg::*;

	typedef struct packed {
		logic [7:0] rte;
		logic [7:0] osc;
		logic [7:0] hpd;
		logic [7:0] pwr;
	} dod_rf_s;

	dod_rf_s st_reg;
	dod_rf_s st_next;

	// mask keeps reserved bits at zero whatever the host writes
	always_comb begin
		st_next = st_reg;
		if (wr_en) begin
			unique case (wr_sel)
				2'h0: st_next.pwr = wr_data & DOD_MASK_PWR;
				2'h1: st_next.hpd = wr_data & DOD_MASK_HPD;
				2'h2: st_next.osc = wr_data & DOD_MASK_OSC;
				2'h3: st_next.rte = wr_data & DOD_MASK_RTE;
			endcase
		end
	end

	// every field back to zero on reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '{DOD_RST_VAL, DOD_RST_VAL, DOD_RST_VAL, DOD_RST_VAL};
		end else begin
			st_reg <= st_next;
		end
	end

	assign regs = st_reg;

	a_fields_reset: assert property (@(posedge pclk) $rose(presetn) |-> regs == 32'h0)
		else $error("fields not zero after reset");
endmodule

// ===== dv/dod_ctrl_regs_tb_top.sv
/*
 * self-checking bench for the output stage control register group:
 * apb read and write tasks, a byte model of the four control registers
 * and call sequences that compare readback and decoded controls.
 * assumes dod_pkg is compiled first; a slave that never answers is caught
 * by the watchdog alone.
 */
`timescale 1ns/1ps
`define CHK(g, e) check_val(32'(g), 32'(e))
module dod_ctrl_regs_tb_top;
	import dod_pkg::*;

	// ************************************************************
	// clock, reset, bus and bench state
	// ************************************************************
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [DOD_ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	dod_ctrl_s ctrl;
	int err_count = 0;
	int samples_checked = 0;
	logic [7:0] m [4]; // expected control bytes
	logic [7:0] idx [4] = '{DOD_IDX_PWR, DOD_IDX_HPD, DOD_IDX_OSC, DOD_IDX_RTE};
	logic [7:0] pv [4] = '{8'h80, 8'h50, 8'he0, 8'h00};
	logic [31:0] rd;
	logic er;

	// 50 mhz clock
	always #10 pclk = ~pclk;

	dod_ctrl_regs i_dod_ctrl_regs (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.ctrl(ctrl)
	);

	// ************************************************************
	// compare, bus and model helpers
	// ************************************************************
	task automatic check_val(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// one apb transfer; request held until pready is seen at a rising edge
	task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no cycle limit here: only the watchdog ends a wait with no answer
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// expected controls from the byte model; no reserved codes are ever written
	function automatic dod_ctrl_s model();
		dod_ctrl_s c;
		c = '0;
		c.left_dac_power = m[0][7];
		c.right_dac_power = m[0][6];
		c.left_companion_driver_mode = m[0][5:4];
		c.right_companion_driver_mode = m[1][5:3];
		c.short_protect_en = m[1][2];
		c.short_protect_shutdown = m[1][2] & m[1][1];
		c.current_limit_active = m[1][2] & ~m[1][1];
		c.common_mode_level = m[2][7:6];
		c.left_line_input_b_bypass = m[2][5:4];
		c.right_line_input_b_bypass = m[2][3:2];
		c.soft_step_mode = m[2][1:0];
		c.left_path_sel = m[3][7:6];
		c.right_path_sel = m[3][5:4];
		c.left_vol_follows_right = (m[3][1:0] == 2'h1);
		c.right_vol_follows_left = (m[3][1:0] == 2'h2);
		return c;
	endfunction

	// write with junk in the unused upper bytes, then check controls and readback
	task automatic wchk(input int k, input logic [7:0] v);
		xfer(1'b1, {idx[k], 2'b00}, {24'ha5a5a5, v}, rd, er);
		m[k] = v;
		@(negedge pclk);
		`CHK(ctrl, model());
		xfer(1'b0, {idx[k], 2'b00}, 32'h0, rd, er);
		`CHK(rd, {24'h0, v});
		`CHK(er, 1'b0);
	endtask

	// controls and all four registers must read back as zero after a reset
	task automatic chk_zero();
		`CHK(ctrl, 24'h0);
		for (int k = 0; k < 4; k++) begin
			xfer(1'b0, {idx[k], 2'b00}, 32'h0, rd, er);
			`CHK(rd, 32'h0);
		end
	endtask

	task automatic tally_and_finish();
		$display("mismatches %0d, comparisons %0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ************************************************************
	// test sequence
	// ************************************************************
	initial begin
		m = '{default: 8'h00};
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		chk_zero();
		// power bits and every legal left companion code
		foreach (pv[i])
			wchk(0, pv[i]);
		// every legal right companion code against all protection settings
		for (int rc = 0; rc < 5; rc++)
			for (int em = 0; em < 4; em++)
				wchk(1, {2'b00, 3'(rc), 2'(em), 1'b0});
		// all common-mode and bypass codes, legal soft-step codes
		for (int i = 0; i < 4; i++)
			wchk(2, {2'(i), 2'(i), 2'(3 - i), 2'(i % 3)});
		// legal routing codes and all four link codes
		for (int i = 0; i < 4; i++)
			wchk(3, {2'(i % 3), 2'((i + 1) % 3), 2'b00, 2'(i)});
		// reserved slot reads zero without error; it is never written
		xfer(1'b0, {DOD_IDX_RSV, 2'b00}, 32'h0, rd, er);
		`CHK(rd, 32'h0);
		`CHK(er, 1'b0);
		// unmapped write is refused and changes nothing; unmapped read errors
		wchk(0, 8'hc0);
		xfer(1'b1, 10'h0a8, 32'hff, rd, er);
		`CHK(er, 1'b1);
		@(negedge pclk);
		`CHK(ctrl, model());
		xfer(1'b0, 10'h000, 32'h0, rd, er);
		`CHK(er, 1'b1);
		`CHK(rd, 32'h0);
		// reset in mid-run clears all fields at once
		@(posedge pclk);
		presetn <= 1'b0;
		@(negedge pclk);
		`CHK(ctrl, 24'h0);
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		m = '{default: 8'h00};
		chk_zero();
		tally_and_finish();
	end

	// watchdog well beyond the few hundred cycles the sequence needs
	initial begin
		#100000;
		err_count++;
		tally_and_finish();
	end
endmodule

// ===== pkg/dod_pkg.sv
/*
 * package for the converter output stage control register group:
 * register offsets, field positions, reset values, mode encodings and
 * the structs that carry the decoded controls.
 * assumes a 32-bit apb slave, one aligned word per register.
 */
// Summary of operation
// - left converter powered while its power bit is set, off when clear
// - right converter powered while its power bit is set, off when clear
// - two-bit left companion driver mode; code three is reserved
// - three-bit right companion driver mode; codes five to seven reserved
// - protection enable bit turns short protection on for all power drivers
// - protection mode bit picks current limit or automatic driver shutdown
// - reserved slot reads zero; host never writes it
// - two-bit common-mode level, four equal steps from low to high
// - left line bypass: off, positive, negative or differential input
// - right line bypass: off, positive, negative or differential input
// - soft-step: per sample, per two samples, disabled; code three reserved
// - left converter routing: first, third or second path; code three reserved
// - right converter routing: first, third or second path; code three reserved
// - volume linking: independent, left follows right, right follows left
package dod_pkg;

	// ************************************************************
	// register indices; the byte address is four times the index
	// ************************************************************
	localparam logic [7:0] DOD_IDX_PWR = 8'h25;
	localparam logic [7:0] DOD_IDX_HPD = 8'h26;
	localparam logic [7:0] DOD_IDX_RSV = 8'h27;
	localparam logic [7:0] DOD_IDX_OSC = 8'h28;
	localparam logic [7:0] DOD_IDX_RTE = 8'h29;
	localparam int DOD_ADDR_W = 10;

	// ************************************************************
	// writable bit masks and reset values
	// ************************************************************
	localparam logic [7:0] DOD_MASK_PWR = 8'hf0;
	localparam logic [7:0] DOD_MASK_HPD = 8'h3e;
	localparam logic [7:0] DOD_MASK_OSC = 8'hff;
	localparam logic [7:0] DOD_MASK_RTE = 8'hf3;
	localparam logic [7:0] DOD_RST_VAL = 8'h00;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int DOD_POS_LPWR = 7;
	localparam int DOD_POS_RPWR = 6;
	localparam int DOD_POS_LCOM = 4;
	localparam int DOD_POS_RCOM = 3;
	localparam int DOD_POS_SCEN = 2;
	localparam int DOD_POS_SCMD = 1;
	localparam int DOD_POS_CML = 6;
	localparam int DOD_POS_LBYP = 4;
	localparam int DOD_POS_RBYP = 2;
	localparam int DOD_POS_STEP = 0;
	localparam int DOD_POS_LRTE = 6;
	localparam int DOD_POS_RRTE = 4;
	localparam int DOD_POS_LINK = 0;

	// ************************************************************
	// reserved codes and link codes
	// ************************************************************
	localparam logic [1:0] DOD_CODE2_RSV = 2'h3;
	localparam logic [2:0] DOD_RCOM_MAX = 3'h4;
	localparam logic [1:0] DOD_LINK_L_FOLLOWS_R = 2'h1;
	localparam logic [1:0] DOD_LINK_R_FOLLOWS_L = 2'h2;

	// apb slave phase states, one-hot
	typedef enum logic [1:0] {
		DOD_ST_IDLE = 2'b01,
		DOD_ST_ACC = 2'b10
	} dod_state_e;

	// decoded controls toward the analogue stage
	typedef struct packed {
		logic left_dac_power;
		logic right_dac_power;
		logic [1:0] left_companion_driver_mode;
		logic [2:0] right_companion_driver_mode;
		logic short_protect_en;
		logic short_protect_shutdown;
		logic current_limit_active;
		logic [1:0] common_mode_level;
		logic [1:0] left_line_input_b_bypass;
		logic [1:0] right_line_input_b_bypass;
		logic [1:0] soft_step_mode;
		logic [1:0] left_path_sel;
		logic [1:0] right_path_sel;
		logic left_vol_follows_right;
		logic right_vol_follows_left;
	} dod_ctrl_s;

	// apb request bundle
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [DOD_ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} dod_apb_req_s;

	// byte address of a register index
	function automatic logic [DOD_ADDR_W-1:0] dod_addr(input logic [7:0] idx);
		return {idx, 2'b00};
	endfunction

endpackage
